/* File: core/rbs_buf2.sv */
/*
 Small valid/ready buffer of flip-flops, two entries by default.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module rbs_buf2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2,
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1,
	localparam int LVL_W = $clog2(DEPTH + 1)
)(
	input  wire logic             clk,       // Clock
	input  wire logic             reset,     // Sync reset
	input  wire logic             in_valid,  // Word offered
	output var  logic             in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Word in
	output var  logic             out_valid, // Word available
	input  wire logic             out_ready, // Drain accepts
	output var  logic [WIDTH-1:0] out_data,  // Word out
	output var  logic [LVL_W-1:0] level      // Words held
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            wp;
		logic [PTR_W-1:0]            rp;
		logic [LVL_W-1:0]            cnt;
	} rbs_buf_st_t;

	rbs_buf_st_t st_ff;
	rbs_buf_st_t nxt_st;
	logic        push;
	logic        pop;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	always_comb begin
		push = in_valid && in_ready;
		pop  = out_valid && out_ready;
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wp] = in_data;
			nxt_st.wp = ptr_inc(st_ff.wp);
		end
		if (pop)
			nxt_st.rp = ptr_inc(st_ff.rp);
		if (push && !pop)
			nxt_st.cnt = st_ff.cnt + 1'b1;
		else if (pop && !push)
			nxt_st.cnt = st_ff.cnt - 1'b1;
		if (reset)
			nxt_st = '0;
	end

	always_ff @(posedge clk) begin
		st_ff <= nxt_st;
	end

	assign in_ready  = (st_ff.cnt != LVL_W'(DEPTH));
	assign out_valid = (st_ff.cnt != '0);
	assign out_data  = st_ff.mem[st_ff.rp];
	assign level     = st_ff.cnt;
endmodule : rbs_buf2
`default_nettype wire

/* File: core/rbs_ctl.sv */
/*
 Controller end: divides ref_clk by two into the link clock, issues
 user commands with the read/write spacing, drives write bursts and
 gathers read bursts into a two-entry buffer.
 Assumes the device is built with the same latencies.
*/
`timescale 1ns/10ps
`default_nettype none
module rbs_ctl
	import rbs_pkg::*;
#(
	parameter int CAS_LAT       = CL_DEF,
	parameter int ADD_LAT       = AL_DEF,
	parameter int WR_COL_LAT    = CWL_DEF,
	parameter bit READ_PRE_2CK  = 1'b0,
	parameter bit WRITE_PRE_2CK = 1'b0
)(
	input  wire logic               ref_clk,        // System clock
	input  wire logic               reset,          // Sync reset
	rbs_link_if.ctl                 link,           // Link pins
	input  wire logic               cmd_valid,      // Command offered
	input  wire rbs_cmd_t           cmd_kind,       // Command kind
	input  wire logic [BANK_W-1:0]  cmd_bank,       // Bank
	input  wire logic [COL_W-1:0]   cmd_col,        // Column or mode
	input  wire logic               cmd_burst_sel,  // Eight when on-the-fly
	input  wire logic               cmd_auto_close, // Close after read burst, at first write pair
	input  wire logic [BURST_W-1:0] cmd_wdata,      // Write burst
	output var  logic               cmd_taken,      // Command accepted
	output var  logic               rd_valid,       // Read burst ready
	input  wire logic               rd_ready,       // Read burst drained
	output var  logic [BURST_W-1:0] rd_data,        // Read burst
	output var  logic               rd_eight        // Burst was eight-beat
);
	localparam int RL = CAS_LAT + ADD_LAT;
	localparam int WL = WR_COL_LAT + ADD_LAT +
	                    (WRITE_PRE_2CK ? WL_PRE2_ADD : 0);
	localparam int WPRE = WRITE_PRE_2CK ? 1 : 0;

	typedef struct packed {
		logic               ck;
		logic               mrst;
		rbs_cmd_t           cmd;
		logic [BANK_W-1:0]  bank;
		logic [COL_W-1:0]   col;
		logic               sel;
		logic               close;
		logic [PAIR_W-1:0]  dq;
		logic               oe_n;
		logic               taken;
		logic [1:0]         mode;
		logic [5:0]         gap;
		logic [5:0]         rw_blk;
		logic [5:0]         wr_blk;
		logic [1:0]         inflight;
		logic [1:0]         q_eight;
		logic [5:0]         wr_wait;
		logic [2:0]         wr_left;
		logic [BURST_W-1:0] wr_data;
		logic [BURST_W-1:0] asm;
		logic [2:0]         asm_cnt;
		logic               push;
		logic [BURST_W:0]   push_data;
		logic [PAIR_W-1:0]  s1_dq;
		logic               s1_stb;
		logic [PAIR_W-1:0]  s2_dq;
		logic               s2_stb;
	} rbs_ctl_st_t;

	rbs_ctl_st_t st_ff;
	rbs_ctl_st_t nxt_st;
	logic [1:0]  level;
	logic        buf_ready;
	logic        eight;
	logic [2:0]  pairs;
	logic        ok;
	logic [1:0]  infl;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ck = !st_ff.ck;
		nxt_st.taken = 1'b0;
		nxt_st.push = 1'b0;
		nxt_st.s1_dq = link.dq;
		nxt_st.s1_stb = link.rd_strobe;
		nxt_st.s2_dq = st_ff.s1_dq;
		nxt_st.s2_stb = st_ff.s1_stb;
		eight = burst_is_eight(st_ff.mode, cmd_burst_sel);
		pairs = burst_pairs(eight);
		infl = st_ff.inflight;
		ok = 1'b0;

		// Falling link edge: launch slot for pins and capture point
		if (st_ff.ck) begin
			nxt_st.mrst = 1'b0;
			nxt_st.cmd = CMD_DES;
			if (st_ff.gap != '1)
				nxt_st.gap = st_ff.gap + 1'b1;
			if (st_ff.rw_blk != '0)
				nxt_st.rw_blk = st_ff.rw_blk - 1'b1;
			if (st_ff.wr_blk != '0)
				nxt_st.wr_blk = st_ff.wr_blk - 1'b1;

			if (st_ff.wr_wait > 6'h01)
				nxt_st.wr_wait = st_ff.wr_wait - 1'b1;
			else if (st_ff.wr_left != '0) begin
				nxt_st.wr_wait = '0;
				nxt_st.dq = st_ff.wr_data[PAIR_W-1:0];
				nxt_st.oe_n = 1'b0;
				nxt_st.wr_data = st_ff.wr_data >> PAIR_W;
				nxt_st.wr_left = st_ff.wr_left - 1'b1;
			end else
				nxt_st.oe_n = 1'b1;

			if (st_ff.s2_stb && st_ff.inflight != '0) begin
				nxt_st.asm[st_ff.asm_cnt*PAIR_W +: PAIR_W] = st_ff.s2_dq;
				nxt_st.asm_cnt = st_ff.asm_cnt + 1'b1;
				if (st_ff.asm_cnt + 1'b1 == burst_pairs(st_ff.q_eight[0])) begin
					nxt_st.push = 1'b1;
					nxt_st.push_data = {st_ff.q_eight[0], nxt_st.asm};
					nxt_st.asm = '0;
					nxt_st.asm_cnt = '0;
					nxt_st.q_eight = {1'b0, st_ff.q_eight[1]};
					infl = st_ff.inflight - 1'b1;
				end
			end

			unique case (cmd_kind)
				CMD_RD: begin
					// Room is reserved in the buffer before the read goes out
					ok = st_ff.gap >= 6'(CCD_MIN) && st_ff.wr_blk == '0 &&
					     !(READ_PRE_2CK && st_ff.gap == 6'(CCD_BAD_PRE2)) &&
					     (3'(level) + 3'(st_ff.push) + 3'(st_ff.inflight)
					      < 3'(BUF_DEPTH));
				end
				CMD_WR: begin
					ok = st_ff.gap >= 6'(CCD_MIN) && st_ff.rw_blk == '0 &&
					     st_ff.wr_blk == '0;
				end
				CMD_ACT, CMD_MRS: begin
					ok = st_ff.inflight == '0 && st_ff.wr_blk == '0 &&
					     st_ff.rw_blk == '0;
				end
				default: begin
					ok = 1'b1;
				end
			endcase

			if (cmd_valid && ok && !st_ff.mrst) begin
				nxt_st.taken = 1'b1;
				nxt_st.cmd = cmd_kind;
				nxt_st.bank = cmd_bank;
				nxt_st.col = cmd_col;
				nxt_st.sel = cmd_burst_sel;
				nxt_st.close = cmd_auto_close;
				if (cmd_kind == CMD_MRS)
					nxt_st.mode = cmd_col[1:0];
				if (cmd_kind == CMD_RD) begin
					// Own slot counted, so gap equals the spacing
					nxt_st.gap = 6'h01;
					nxt_st.rw_blk = 6'(RL + int'(pairs) + TURN_CK + WPRE - WL - 1);
					nxt_st.q_eight[infl[0]] = eight;
					infl = infl + 1'b1;
				end
				if (cmd_kind == CMD_WR) begin
					nxt_st.gap = 6'h01;
					nxt_st.wr_blk = 6'(WL + int'(pairs) + WR_RD_GAP - 1);
					nxt_st.wr_wait = 6'(WL);
					nxt_st.wr_left = pairs;
					nxt_st.wr_data = cmd_wdata;
				end
			end
			nxt_st.inflight = infl;
		end

		if (reset) begin
			nxt_st = '0;
			nxt_st.mrst = 1'b1;
			nxt_st.oe_n = 1'b1;
			nxt_st.cmd = CMD_DES;
			nxt_st.mode = MODE_RST;
			nxt_st.gap = '1;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_ff <= nxt_st;
	end

	rbs_buf2 #(
		.WIDTH (BURST_W + 1),
		.DEPTH (BUF_DEPTH)
	) u_rd_buf (
		.clk       (ref_clk),
		.reset     (reset),
		.in_valid  (st_ff.push),
		.in_ready  (buf_ready),
		.in_data   (st_ff.push_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  ({rd_eight, rd_data}),
		.level     (level)
	);

	assign link.ck         = st_ff.ck;
	assign link.mem_reset  = st_ff.mrst;
	assign link.cmd        = st_ff.cmd;
	assign link.bank       = st_ff.bank;
	assign link.col        = st_ff.col;
	assign link.burst_sel  = st_ff.sel;
	assign link.auto_close = st_ff.close;
	assign link.dq_ctl     = st_ff.dq;
	assign link.ctl_oe_n   = st_ff.oe_n;
	assign cmd_taken       = st_ff.taken;
endmodule : rbs_ctl
`default_nettype wire

/* File: core/rbs_dev.sv */
/*
 Device end: decodes commands on the link clock, schedules read and
 write bursts by latency, drives and releases the data pins, keeps
 bank open state and flags protocol faults.
 Assumes the controller launches commands and write data half a link
 clock before the rising edge and keeps the spacing rules.
*/
`timescale 1ns/10ps
`default_nettype none
module rbs_dev
	import rbs_pkg::*;
#(
	parameter int CAS_LAT      = CL_DEF,
	parameter int ADD_LAT      = AL_DEF,
	parameter int WRITE_LAT    = CWL_DEF + AL_DEF,
	parameter bit READ_PRE_2CK = 1'b0
)(
	rbs_link_if.dev                link,        // Link pins
	output var logic [1:0]         burst_field, // Current burst field
	output var logic [NBANK-1:0]   bank_open,   // Open bank flags
	output var logic               rd_busy,     // Driving read data
	output var logic               rd_eight,    // Last read was eight-beat
	output var logic [ERR_W-1:0]   err_flags    // Sticky fault flags
);
	localparam int RL = CAS_LAT + ADD_LAT;

	typedef struct packed {
		logic              v;
		logic              wr;
		logic              eight;
		logic              close;
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0]  col;
	} rbs_slot_t;

	typedef struct packed {
		rbs_slot_t [LAT_MAX-1:0]              pipe;
		logic [(1<<COL_W)-1:0][PAIR_W-1:0]    mem;
		logic [1:0]                           mode;
		logic [NBANK-1:0]                     open;
		logic [2:0]                           rd_left;
		logic [COL_W-1:0]                     rd_col;
		logic                                 rd_close;
		logic [BANK_W-1:0]                    rd_bank;
		logic                                 rd_eight;
		logic [2:0]                           wr_left;
		logic [COL_W-1:0]                     wr_col;
		logic [PAIR_W-1:0]                    dq;
		logic                                 oe_n;
		logic [5:0]                           gap;
		logic [ERR_W-1:0]                     err;
	} rbs_dev_st_t;

	rbs_dev_st_t st_ff;
	rbs_dev_st_t nxt_st;
	rbs_slot_t   slot;
	logic        col_cmd;
	int          lat;

	always_comb begin
		nxt_st = st_ff;
		slot = '0;
		lat = RL;
		col_cmd = (link.cmd == CMD_RD) || (link.cmd == CMD_WR);

		for (int i = 0; i < LAT_MAX - 1; i++) begin
			nxt_st.pipe[i] = st_ff.pipe[i + 1];
		end
		nxt_st.pipe[LAT_MAX-1] = '0;

		if (st_ff.gap != '1)
			nxt_st.gap = st_ff.gap + 1'b1;

		// Read engine: release once the last pair has stood a clock
		if (st_ff.rd_left != '0) begin
			nxt_st.dq = st_ff.mem[st_ff.rd_col];
			nxt_st.rd_col = st_ff.rd_col + 1'b1;
			nxt_st.rd_left = st_ff.rd_left - 1'b1;
		end else if (!st_ff.oe_n) begin
			nxt_st.oe_n = 1'b1;
			nxt_st.dq = '0;
			if (st_ff.rd_close)
				nxt_st.open[st_ff.rd_bank] = 1'b0;
		end

		if (st_ff.pipe[0].v && !st_ff.pipe[0].wr) begin
			nxt_st.dq = st_ff.mem[st_ff.pipe[0].col];
			nxt_st.oe_n = 1'b0;
			nxt_st.rd_col = st_ff.pipe[0].col + 1'b1;
			nxt_st.rd_left = burst_pairs(st_ff.pipe[0].eight) - 1'b1;
			nxt_st.rd_close = st_ff.pipe[0].close;
			nxt_st.rd_bank = st_ff.pipe[0].bank;
			nxt_st.rd_eight = st_ff.pipe[0].eight;
		end

		// Write engine: one pair taken per rising edge
		if (st_ff.wr_left != '0) begin
			nxt_st.mem[st_ff.wr_col] = link.dq;
			nxt_st.wr_col = st_ff.wr_col + 1'b1;
			nxt_st.wr_left = st_ff.wr_left - 1'b1;
		end
		if (st_ff.pipe[0].v && st_ff.pipe[0].wr) begin
			nxt_st.mem[st_ff.pipe[0].col] = link.dq;
			nxt_st.wr_col = st_ff.pipe[0].col + 1'b1;
			nxt_st.wr_left = burst_pairs(st_ff.pipe[0].eight) - 1'b1;
			if (st_ff.pipe[0].close)
				nxt_st.open[st_ff.pipe[0].bank] = 1'b0;
		end

		unique case (link.cmd)
			CMD_DES: begin
			end
			CMD_ACT: begin
				nxt_st.open[link.bank] = 1'b1;
			end
			CMD_MRS: begin
				nxt_st.mode = link.col[1:0];
			end
			CMD_RD, CMD_WR: begin
				slot.v = 1'b1;
				slot.wr = (link.cmd == CMD_WR);
				slot.eight = burst_is_eight(st_ff.mode, link.burst_sel);
				slot.close = link.auto_close;
				slot.bank = link.bank;
				slot.col = link.col;
				lat = slot.wr ? WRITE_LAT : RL;
			end
			default: begin
			end
		endcase

		if (col_cmd) begin
			// Insert one short so the slot reaches the tail at latency
			if (nxt_st.pipe[lat - 1].v)
				nxt_st.err[ERR_CLASH] = 1'b1;
			nxt_st.pipe[lat - 1] = slot;
			if (!st_ff.open[link.bank])
				nxt_st.err[ERR_CLOSED] = 1'b1;
			if (st_ff.gap < 6'(CCD_MIN) ||
			    (READ_PRE_2CK && link.cmd == CMD_RD &&
			     st_ff.gap == 6'(CCD_BAD_PRE2)))
				nxt_st.err[ERR_SPACE] = 1'b1;
			// Own slot counted, so gap equals the spacing
			nxt_st.gap = 6'h01;
		end

		if (link.mem_reset) begin
			nxt_st = '0;
			nxt_st.oe_n = 1'b1;
			nxt_st.mode = MODE_RST;
			nxt_st.gap = '1;
		end
	end

	always_ff @(posedge link.ck) begin
		st_ff <= nxt_st;
	end

	assign link.dq_dev   = st_ff.dq;
	assign link.dev_oe_n = st_ff.oe_n;
	assign burst_field   = st_ff.mode;
	assign bank_open     = st_ff.open;
	assign rd_busy       = !st_ff.oe_n;
	assign rd_eight      = st_ff.rd_eight;
	assign err_flags     = st_ff.err;
endmodule : rbs_dev
`default_nettype wire

/* File: core/rbs_link_if.sv */
/*
 Link between controller and device: command, address and the shared
 data pins with one drive enable per end.
 Assumes only one end enables its drivers at a time.
*/
`timescale 1ns/10ps
`default_nettype none
interface rbs_link_if
	import rbs_pkg::*;
();
	logic              ck;
	logic              mem_reset;
	rbs_cmd_t          cmd;
	logic [BANK_W-1:0] bank;
	logic [COL_W-1:0]  col;
	logic              burst_sel;
	logic              auto_close;
	logic [PAIR_W-1:0] dq_dev;
	logic [PAIR_W-1:0] dq_ctl;
	logic [PAIR_W-1:0] dq;
	logic              dev_oe_n;
	logic              ctl_oe_n;
	logic              rd_strobe;

	// Undriven pins read as zero
	assign dq = !dev_oe_n ? dq_dev : (!ctl_oe_n ? dq_ctl : '0);
	assign rd_strobe = !dev_oe_n;

	modport dev (
		input  ck, mem_reset, cmd, bank, col, burst_sel, auto_close, dq,
		output dq_dev, dev_oe_n
	);

	modport ctl (
		output ck, mem_reset, cmd, bank, col, burst_sel, auto_close,
		output dq_ctl, ctl_oe_n,
		input  dq, rd_strobe
	);
endinterface : rbs_link_if
`default_nettype wire

/* File: core/rbs_pad.sv */
/*
 Holds no logic; the block's modules live in the other core files.
 Assumes nothing of its surroundings.
*/

/* File: core/rbs_pkg.sv */
/*
 Shared constants, types and helpers for the read burst sequencing
 link: burst field codes, commands, latencies and spacing counts.
 Assumes both ends and the link interface import it whole.
*/
// Overview of operation
// - Field 00, or 01 with select high: eight
// - Field 10, or 01 with select low: chop
// - Burst length decided anew for every read
// - Two-clock read preamble forbids spacing of five
// - Two-clock write preamble adds one to latency
// - Data starts cas plus additive latency later
// - Eight-beat burst releases pins at latency plus four
// - Chopped burst releases pins at latency plus two
// - Auto-close bit high closes bank after a read burst, at the first pair of a write
package rbs_pkg;

	localparam int DQ_W   = 8;
	localparam int PAIR_W = 2 * DQ_W;
	localparam int COL_W  = 4;
	localparam int BANK_W = 2;
	localparam int NBANK  = 1 << BANK_W;
	localparam int BURST_W = 4 * PAIR_W;

	localparam logic [1:0] BF_EIGHT = 2'h0;
	localparam logic [1:0] BF_OTF   = 2'h1;
	localparam logic [1:0] BF_CHOP  = 2'h2;
	localparam logic [1:0] MODE_RST = BF_EIGHT;

	localparam logic [2:0] PAIRS_EIGHT = 3'h4;
	localparam logic [2:0] PAIRS_CHOP  = 3'h2;

	localparam int CL_DEF       = 11;
	localparam int AL_DEF       = 0;
	localparam int CWL_DEF      = 9;
	localparam int CCD_MIN      = 4;
	localparam int CCD_BAD_PRE2 = 5;
	localparam int WL_PRE2_ADD  = 1;
	localparam int TURN_CK      = 2;
	localparam int WR_RD_GAP    = 1;
	localparam int LAT_MAX      = 32;
	localparam int BUF_DEPTH    = 2;

	localparam int ERR_W      = 3;
	localparam int ERR_CLOSED = 0;
	localparam int ERR_SPACE  = 1;
	localparam int ERR_CLASH  = 2;

	typedef enum logic [2:0] {
		CMD_DES,
		CMD_ACT,
		CMD_RD,
		CMD_WR,
		CMD_MRS
	} rbs_cmd_t;

	function automatic logic burst_is_eight(input logic [1:0] field,
	                                        input logic       sel);
		burst_is_eight = (field == BF_EIGHT) ||
		                 (field == BF_OTF && sel);
	endfunction : burst_is_eight

	function automatic logic [2:0] burst_pairs(input logic eight);
		burst_pairs = eight ? PAIRS_EIGHT : PAIRS_CHOP;
	endfunction : burst_pairs

endpackage : rbs_pkg

/* File: tb/rbs_link_checker.sv */
/*
 Checker on the link: burst windows, write drive, command spacing.
 Assumes tb instantiates it beside the link with matching latencies.
*/
`timescale 1ns/10ps
`default_nettype none
module rbs_link_checker
	import rbs_pkg::*;
#(
	parameter int CAS_LAT      = CL_DEF,
	parameter int ADD_LAT      = AL_DEF,
	parameter int WRITE_LAT    = CWL_DEF + AL_DEF,
	parameter bit READ_PRE_2CK = 1'b0
)(
	input wire logic             ck,        // Link clock
	input wire logic             mem_reset, // Device reset
	input wire rbs_cmd_t         cmd,       // Command
	input wire logic [COL_W-1:0] col,       // Column or mode
	input wire logic             burst_sel, // On-the-fly select
	input wire logic             dev_oe_n,  // Device drive, low on
	input wire logic             ctl_oe_n   // Controller drive, low on
);
	localparam int RD_E = CAS_LAT + ADD_LAT;
	localparam int RD_D = RD_E + 1;
	logic [1:0] mode_ff;
	logic       eight;

	default clocking cb @(posedge ck); endclocking
	default disable iff (mem_reset);

	always_ff @(posedge ck) begin
		if (mem_reset) begin
			mode_ff <= MODE_RST;
		end else if (cmd == CMD_MRS) begin
			mode_ff <= col[1:0];
		end
	end
	// Field 11 falls through to chop
	assign eight = mode_ff == BF_EIGHT || (mode_ff == BF_OTF && burst_sel);

	sequence rd8_s;
		cmd == CMD_RD && eight;
	endsequence
	sequence rd4_s;
		cmd == CMD_RD && !eight;
	endsequence
	sequence wr8_s;
		cmd == CMD_WR && eight;
	endsequence
	sequence wr4_s;
		cmd == CMD_WR && !eight;
	endsequence

	chk_rd_eight_beats: assert property (
		rd8_s |-> ##RD_D (!dev_oe_n) [*4]) else $error("eight read window");
	chk_rd_chop_beats: assert property (
		rd4_s |-> ##RD_D (!dev_oe_n) [*2] ##1 dev_oe_n)
		else $error("chop read window");
	chk_rd_eight_rel: assert property (
		rd8_s ##1 (cmd != CMD_RD) [*4] |-> ##RD_D dev_oe_n)
		else $error("eight read not released");
	chk_rd_no_early: assert property (
		(cmd != CMD_RD) [*5] ##1 cmd == CMD_RD |-> ##RD_E dev_oe_n)
		else $error("read data too early");
	chk_rd_gap_des: assert property (
		cmd == CMD_RD |=> (cmd == CMD_DES) [*3]) else $error("idle not deselect");
	chk_no_gap_five: assert property (
		cmd == CMD_RD |-> ##5 !(READ_PRE_2CK && cmd == CMD_RD))
		else $error("reads spaced by five");
	chk_wr_eight_drive: assert property (
		wr8_s |-> ##WRITE_LAT (!ctl_oe_n) [*4] ##1 ctl_oe_n)
		else $error("eight write window");
	chk_wr_chop_drive: assert property (
		wr4_s |-> ##WRITE_LAT (!ctl_oe_n) [*2] ##1 ctl_oe_n)
		else $error("chop write window");
	chk_bus_turn: assert property (
		!(!dev_oe_n && !ctl_oe_n)) else $error("both ends drive");
endmodule : rbs_link_checker
`default_nettype wire

/* File: tb/tb.sv */
/*
 Bench: controller and device joined by the link, checker beside it.
 Assumes two-clock preambles on both ends and matching write latency.
*/
`timescale 1ns/10ps
`default_nettype none
module tb
	import rbs_pkg::*;
;
	localparam int WL = CWL_DEF + AL_DEF + WL_PRE2_ADD;
	logic               ref_clk = 1'b0;
	logic               reset = 1'b1;
	logic               cmd_valid = 1'b0;
	rbs_cmd_t           cmd_kind = CMD_DES;
	logic [BANK_W-1:0]  cmd_bank = '0;
	logic [COL_W-1:0]   cmd_col = '0;
	logic               cmd_burst_sel = 1'b0;
	logic               cmd_auto_close = 1'b0;
	logic [BURST_W-1:0] cmd_wdata = '0;
	logic               rd_ready = 1'b0;
	logic               cmd_taken, rd_valid, rd_eight;
	logic [BURST_W-1:0] rd_data;
	logic [1:0]         burst_field;
	logic [NBANK-1:0]   bank_open;
	logic [ERR_W-1:0]   err_flags;
	logic [1:0]         mode = MODE_RST;
	logic [PAIR_W-1:0]  exp_mem [1 << COL_W];
	logic               last_e = 1'b0;
	logic               dev_busy, dev_eight;
	logic [63:0]        exp_q [$];
	logic               exp_e [$];
	int                 err_count = 0;
	int                 n_compared = 0;
	int                 taken_n = 0;

	rbs_link_if link ();
	rbs_ctl #(.READ_PRE_2CK(1'b1), .WRITE_PRE_2CK(1'b1)) rbs_ctl_i (
		.ref_clk(ref_clk), .reset(reset), .link(link),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
		.cmd_col(cmd_col), .cmd_burst_sel(cmd_burst_sel),
		.cmd_auto_close(cmd_auto_close), .cmd_wdata(cmd_wdata),
		.cmd_taken(cmd_taken), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_data(rd_data), .rd_eight(rd_eight));
	rbs_dev #(.WRITE_LAT(WL), .READ_PRE_2CK(1'b1)) rbs_dev_i (
		.link(link), .burst_field(burst_field), .bank_open(bank_open),
		.rd_busy(dev_busy), .rd_eight(dev_eight), .err_flags(err_flags));
	rbs_link_checker #(.WRITE_LAT(WL), .READ_PRE_2CK(1'b1))
	rbs_link_checker_i (.ck(link.ck), .mem_reset(link.mem_reset),
		.cmd(link.cmd), .col(link.col), .burst_sel(link.burst_sel),
		.dev_oe_n(link.dev_oe_n), .ctl_oe_n(link.ctl_oe_n));

	always #50 ref_clk = ~ref_clk;

	task automatic check(input logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h",
			         $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	function automatic logic [63:0] pat(input logic [1:0] b,
	                                    input logic [3:0] c);
		return 64'h0123_4567_89ab_cdef ^ {16{c}} ^ {32{b}};
	endfunction : pat

	function automatic logic eight_of(input logic s);
		return mode == BF_EIGHT || (mode == BF_OTF && s);
	endfunction : eight_of

	task automatic issue(input rbs_cmd_t k, input logic [1:0] b,
	                     input logic [3:0] c, input logic s, a);
		int n;
		n = 0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_bank <= b;
		cmd_col <= c;
		cmd_burst_sel <= s;
		cmd_auto_close <= a;
		cmd_wdata <= pat(b, c);
		do begin
			@(negedge ref_clk);
			n++;
		end while (cmd_taken !== 1'b1 && n < 500);
		check(cmd_taken, 1'b1);
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
	endtask : issue

	task automatic wr(input logic [1:0] b, input logic [3:0] c,
	                  input logic s);
		logic [63:0] w;
		w = pat(b, c);
		issue(CMD_WR, b, c, s, 1'b0);
		// One store for all banks; columns wrap, so bursts overlap
		for (int p = 0; p < (eight_of(s) ? PAIRS_EIGHT : PAIRS_CHOP); p++)
			exp_mem[4'(c + p)] = w[PAIR_W*p +: PAIR_W];
	endtask : wr

	task automatic rd(input logic [1:0] b, input logic [3:0] c,
	                  input logic s, a);
		logic [63:0] m;
		m = '0;
		for (int p = 0; p < (eight_of(s) ? PAIRS_EIGHT : PAIRS_CHOP); p++)
			m[PAIR_W*p +: PAIR_W] = exp_mem[4'(c + p)];
		exp_q.push_back(m);
		exp_e.push_back(eight_of(s));
		last_e = eight_of(s);
		issue(CMD_RD, b, c, s, a);
	endtask : rd

	task automatic mrs(input logic [1:0] f);
		issue(CMD_MRS, 2'h0, {2'h0, f}, 1'b0, 1'b0);
		mode = f;
		repeat (2) @(posedge ref_clk);
		check(burst_field, f);
	endtask : mrs

	task automatic drain(input string name);
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		check(exp_q.size(), 0);
		repeat (8) @(posedge ref_clk);
		check(dev_busy, 1'b0);
		check(dev_eight, last_e);
		$display("test %s done", name);
	endtask : drain

	// Head is compared at the falling edge before the handshake edge
	always @(negedge ref_clk) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(1'b1, 1'b0);
			end else begin
				check(rd_data, exp_q.pop_front());
				check(rd_eight, exp_e.pop_front());
			end
		end
	end

	always @(posedge ref_clk) begin
		if (cmd_taken === 1'b1) begin
			taken_n <= taken_n + 1;
		end
	end

	initial begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		print_verdict();
	end

	initial begin
		int k;
		// Device store is cleared by its reset
		foreach (exp_mem[i]) exp_mem[i] = '0;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rd_ready <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check(burst_field, MODE_RST);
		check(bank_open, 4'h0);
		check(rd_valid, 1'b0);
		issue(CMD_ACT, 2'h0, 4'h0, 1'b0, 1'b0);
		issue(CMD_ACT, 2'h1, 4'h0, 1'b0, 1'b0);
		repeat (2) @(posedge ref_clk);
		check(bank_open, 4'h3);
		for (int c = 0; c < 6; c++) wr(2'h0, c[3:0], 1'b0);
		for (int c = 0; c < 4; c++) rd(2'h0, c[3:0], 1'b0, 1'b0);
		drain("fixed eight");
		mrs(BF_OTF);
		rd(2'h0, 4'h0, 1'b1, 1'b0);
		rd(2'h0, 4'h1, 1'b0, 1'b0);
		rd(2'h0, 4'h2, 1'b0, 1'b0);
		rd(2'h0, 4'h3, 1'b1, 1'b0);
		wr(2'h0, 4'h4, 1'b1);
		rd(2'h0, 4'h2, 1'b0, 1'b0);
		wr(2'h0, 4'h1, 1'b0);
		rd(2'h0, 4'h1, 1'b1, 1'b0);
		rd(2'h0, 4'h4, 1'b1, 1'b0);
		drain("on the fly");
		// Stalled drain: third read must wait for buffer room
		k = taken_n;
		@(posedge ref_clk);
		rd_ready <= 1'b0;
		rd(2'h0, 4'h0, 1'b1, 1'b0);
		rd(2'h0, 4'h3, 1'b0, 1'b0);
		fork
			rd(2'h0, 4'h5, 1'b1, 1'b0);
			begin
				repeat (150) @(posedge ref_clk);
				check(taken_n, k + 2);
				check(rd_valid, 1'b1);
				rd_ready <= 1'b1;
			end
		join
		drain("buffer stall");
		for (int f = 2; f < 4; f++) begin
			mrs(f[1:0]);
			rd(2'h0, 4'h0, 1'b1, 1'b0);
			rd(2'h0, 4'h5, 1'b1, 1'b0);
		end
		drain("fixed chop");
		mrs(BF_EIGHT);
		wr(2'h1, 4'h0, 1'b0);
		rd(2'h1, 4'h0, 1'b0, 1'b1);
		rd(2'h0, 4'h2, 1'b0, 1'b0);
		drain("auto close");
		check(bank_open, 4'h1);
		check(err_flags, 3'h0);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
